//--- shared/trace_unit_pkg.sv
package trace_unit_pkg;
	// Register indices within the nine-byte register window
	localparam logic [3:0] OFS_CMP_A_HIGH = 4'h0;
	localparam logic [3:0] OFS_CMP_A_LOW = 4'h1;
	localparam logic [3:0] OFS_CMP_B_HIGH = 4'h2;
	localparam logic [3:0] OFS_CMP_B_LOW = 4'h3;
	localparam logic [3:0] OFS_FIFO_HIGH = 4'h4;
	localparam logic [3:0] OFS_FIFO_LOW = 4'h5;
	localparam logic [3:0] OFS_CONTROL = 4'h6;
	localparam logic [3:0] OFS_TRIGGER = 4'h7;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	// Control register field positions
	localparam int CTRL_ENABLE_BIT = 7;
	localparam int CTRL_ARM_BIT = 6;
	localparam int CTRL_TAG_BIT = 5;
	localparam int CTRL_BREAK_REQUEST_ENABLE_BIT = 4;
	localparam int CTRL_DIR_A_BIT = 3;
	localparam int CTRL_DIRQ_A_BIT = 2;
	localparam int CTRL_DIR_B_BIT = 1;
	localparam int CTRL_DIRQ_B_BIT = 0;
	// Trigger register field positions; bits 5:4 always read zero
	localparam int TRIG_SELECT_BIT = 7;
	localparam int TRIG_BEGIN_BIT = 6;
	localparam logic [7:0] TRIG_WRITE_MASK = 8'hcf;
	// Reset values
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] TRIG_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// Trigger mode codes
	localparam logic [3:0] MODE_A_ONLY = 4'h0;
	localparam logic [3:0] MODE_A_OR_B = 4'h1;
	localparam logic [3:0] MODE_A_THEN_B = 4'h2;
	localparam logic [3:0] MODE_EVT_B = 4'h3;
	localparam logic [3:0] MODE_A_EVT_B = 4'h4;
	localparam logic [3:0] MODE_A_AND_B = 4'h5;
	localparam logic [3:0] MODE_A_NOT_B = 4'h6;
	localparam logic [3:0] MODE_INSIDE = 4'h7;
	localparam logic [3:0] MODE_OUTSIDE = 4'h8;
	// Buffer geometry
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] FIFO_FULL = 4'h8;
	// Run sequencer states, Gray along idle, wait, store
	typedef enum logic [1:0] {
		RUN_IDLE = 2'b00,
		RUN_WAIT = 2'b01,
		RUN_STORE = 2'b11
	} run_state_t;
endpackage

//--- shared/fifo_port_if.sv
interface fifo_port_if #(parameter int WIDTH = 16);
	// Capture push, armed only
	logic push;
	logic [WIDTH-1:0] push_data;
	// Read pop, unarmed only, refills the last slot
	logic pop;
	logic [WIDTH-1:0] pop_fill;
	// Oldest word, presented to the read port
	logic [WIDTH-1:0] head;
	modport owner (output push, output push_data, output pop, output pop_fill, input head);
	modport store (input push, input push_data, input pop, input pop_fill, output head);
endinterface

//--- rtl/address_comparator.sv
module address_comparator #(
	parameter int AW = 16
) (
	// Clock and reset, only for checking
	input wire logic ref_clk,
	input wire logic rst_n,
	// Setup
	input wire logic enable,
	input wire logic [AW-1:0] value,
	input wire logic dir_qualify,
	input wire logic dir_value,
	// Bus probe
	input wire logic [AW-1:0] addr,
	input wire logic rw,
	input wire logic valid,
	// Result
	output logic hit
);
	// Direction only matters when qualification is on
	always_comb begin
		hit = enable && valid && (addr == value) && (!dir_qualify || (rw == dir_value)); // R15 R16 R20
	end

	a_dir_filter: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hit && dir_qualify |-> rw == dir_value) // R15
		else $error("comparator matched on wrong direction");
	a_addr_equal: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hit |-> addr == value && enable) // R20
		else $error("comparator hit without address equality");
endmodule

//--- rtl/trace_fifo.sv
module trace_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Owner side
	fifo_port_if.store port
);
	// Shift chain, slot 0 is oldest
	logic [WIDTH-1:0] words [DEPTH];

	// Push or pop both shift toward slot 0 and load the top
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				words[i] <= '0;
			end
		end else if (port.push || port.pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				words[i] <= words[i+1];
			end
			words[DEPTH-1] <= port.push ? port.push_data : port.pop_fill; // R8 R9
		end
	end

	// Head is a flop output
	always_comb begin
		port.head = words[0];
	end

	a_fill_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
		port.pop && !port.push |=> words[DEPTH-1] == $past(port.pop_fill)) // R8
		else $error("profiling address not stored in last slot");
	a_depth_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
		port.pop && !port.push ##1 (port.pop && !port.push)[*7] |=> port.head == $past(port.pop_fill, 8)) // R9
		else $error("ninth read does not return first profiled address");
	c_profile_run: cover property (@(posedge ref_clk) disable iff (!rst_n)
		(port.pop)[*8]);
endmodule

//--- rtl/trace_unit.sv
// How it works
// R1: Two 16-bit comparators, high/low byte registers
// R2: Comparator bytes reset zero, locked while armed
// R3: Buffer registers read-only, writes ignored
// R4: Event-only modes: high byte reads zero
// R5: High byte read never advances buffer
// R6: Each low byte read advances buffer; code advances only when unarmed
// R7: Software avoids buffer reads while armed
// R8: Unarmed low read stores last opcode address
// R9: Profiling acts as eight-deep shift
// R10: Control register accessible at any time
// R11: Enable cannot be set while secure
// R12: Arm sets flag; completion or disable clears
// R13: Bit 5 picks tag or force break
// R14: Bit 4 enables break on trigger
// R15: Comparator A optional direction qualification
// R16: Comparator B optional direction qualification
// R17: Qualification choice never moves break timing
// R18: Run ends on full or trigger
// R19: Modes 3, 4 store B events
// R20: Disabled unit: no match, capture, break
module trace_unit #(
	parameter int AW = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register access port
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// CPU bus probe
	input wire logic [AW-1:0] cpu_addr,
	input wire logic [7:0] cpu_data,
	input wire logic cpu_rw,
	input wire logic cpu_valid,
	input wire logic cpu_fetch,
	input wire logic cpu_secure,
	// Break requests to the CPU
	output logic brk_req,
	output logic brk_tag
);
	// Comparator values
	logic [AW-1:0] cmp_a_reg;
	logic [AW-1:0] cmp_b_reg;
	// Control and trigger setup
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [7:0] trig_reg;
	// Run status
	logic af_reg;
	logic bf_reg;
	logic [3:0] cnt_reg;
	trace_unit_pkg::run_state_t state_reg;
	trace_unit_pkg::run_state_t state_next;
	// Address of the latest opcode fetch
	logic [AW-1:0] last_fetch_reg;
	// Outputs held in flops
	logic [7:0] rdata_reg;
	logic brk_req_reg;
	logic brk_tag_reg;
	// Decode and event terms
	logic armed;
	logic arm_rise;
	logic hit_a;
	logic hit_b;
	logic qual;
	logic a_ev;
	logic b_ev;
	logic trig_ev;
	logic event_only;
	logic begin_trace;
	logic run_done;
	logic [7:0] rd_mux;

	fifo_port_if #(.WIDTH(AW)) fport ();

	// Range test used by both range modes
	function automatic logic in_range(input logic [AW-1:0] a, input logic [AW-1:0] lo,
			input logic [AW-1:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Trigger condition for each mode; event-only and unused codes never fire
	function automatic logic mode_hit(input logic [3:0] mode, input logic a, input logic b,
			input logic a_before, input logic inr);
		case (mode)
			trace_unit_pkg::MODE_A_ONLY: mode_hit = a;
			trace_unit_pkg::MODE_A_OR_B: mode_hit = a || b;
			trace_unit_pkg::MODE_A_THEN_B: mode_hit = b && a_before;
			trace_unit_pkg::MODE_A_AND_B: mode_hit = a && b;
			trace_unit_pkg::MODE_A_NOT_B: mode_hit = a && !b;
			trace_unit_pkg::MODE_INSIDE: mode_hit = inr;
			trace_unit_pkg::MODE_OUTSIDE: mode_hit = !inr;
			default: mode_hit = 1'b0;
		endcase
	endfunction

	// Comparator A and B
	address_comparator #(.AW(AW)) u_cmp_a (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.enable(ctrl_reg[trace_unit_pkg::CTRL_ENABLE_BIT]),
		.value(cmp_a_reg),
		.dir_qualify(ctrl_reg[trace_unit_pkg::CTRL_DIRQ_A_BIT]),
		.dir_value(ctrl_reg[trace_unit_pkg::CTRL_DIR_A_BIT]),
		.addr(cpu_addr),
		.rw(cpu_rw),
		.valid(cpu_valid),
		.hit(hit_a)
	);
	address_comparator #(.AW(AW)) u_cmp_b (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.enable(ctrl_reg[trace_unit_pkg::CTRL_ENABLE_BIT]),
		.value(cmp_b_reg),
		.dir_qualify(ctrl_reg[trace_unit_pkg::CTRL_DIRQ_B_BIT]),
		.dir_value(ctrl_reg[trace_unit_pkg::CTRL_DIR_B_BIT]),
		.addr(cpu_addr),
		.rw(cpu_rw),
		.valid(cpu_valid),
		.hit(hit_b)
	);

	// Capture buffer
	trace_fifo #(.WIDTH(AW), .DEPTH(trace_unit_pkg::FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.port(fport)
	);

	// Match qualification and mode decode
	always_comb begin
		armed = ctrl_reg[trace_unit_pkg::CTRL_ARM_BIT];
		// Tag-style qualification keeps only opcode fetches
		qual = !trig_reg[trace_unit_pkg::TRIG_SELECT_BIT] || cpu_fetch;
		a_ev = armed && hit_a && qual; // R20
		b_ev = armed && hit_b && qual; // R20
		event_only = (trig_reg[3:0] == trace_unit_pkg::MODE_EVT_B) ||
			(trig_reg[3:0] == trace_unit_pkg::MODE_A_EVT_B); // R19
		// Event-only runs are always begin traces
		begin_trace = trig_reg[trace_unit_pkg::TRIG_BEGIN_BIT] || event_only;
		trig_ev = armed && cpu_valid && qual && ctrl_reg[trace_unit_pkg::CTRL_ENABLE_BIT] &&
			mode_hit(trig_reg[3:0], hit_a, hit_b, af_reg,
			in_range(cpu_addr, cmp_a_reg, cmp_b_reg));
	end

	// Buffer write port: pushes while storing, pops on unarmed low reads
	always_comb begin
		fport.push = 1'b0;
		if (state_reg == trace_unit_pkg::RUN_STORE && armed) begin
			if (event_only) begin
				fport.push = b_ev; // R19
			end else begin
				fport.push = cpu_valid && cpu_fetch;
			end
		end
		// Event data keeps only the low byte
		fport.push_data = event_only ? {trace_unit_pkg::ZERO_BYTE, cpu_data} : cpu_addr; // R4
		// Held still while armed so reads cannot disturb capture
		fport.pop = reg_rd && (reg_addr == trace_unit_pkg::OFS_FIFO_LOW) && !armed; // R6 R7
		fport.pop_fill = last_fetch_reg; // R8
	end

	// Run completion: full for begin traces, trigger for end traces
	always_comb begin
		run_done = 1'b0;
		if (state_reg == trace_unit_pkg::RUN_STORE && armed) begin
			if (begin_trace) begin
				run_done = fport.push && (cnt_reg == trace_unit_pkg::FIFO_FULL - 4'h1); // R18
			end else begin
				run_done = trig_ev; // R18
			end
		end
	end

	// Control write; a software set wins over completion
	always_comb begin
		ctrl_next = ctrl_reg;
		if (run_done) begin
			ctrl_next[trace_unit_pkg::CTRL_ARM_BIT] = 1'b0; // R12
		end
		if (reg_wr && reg_addr == trace_unit_pkg::OFS_CONTROL) begin
			ctrl_next = reg_wdata; // R10
			ctrl_next[trace_unit_pkg::CTRL_ENABLE_BIT] =
				reg_wdata[trace_unit_pkg::CTRL_ENABLE_BIT] && !cpu_secure; // R11
		end
		// Arm cannot outlive the enable
		if (!ctrl_next[trace_unit_pkg::CTRL_ENABLE_BIT]) begin
			ctrl_next[trace_unit_pkg::CTRL_ARM_BIT] = 1'b0; // R12
		end
		arm_rise = ctrl_next[trace_unit_pkg::CTRL_ARM_BIT] && !armed;
	end

	// Control register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_reg <= trace_unit_pkg::CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Comparator and trigger setup, frozen while armed
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmp_a_reg <= {trace_unit_pkg::CMP_RESET, trace_unit_pkg::CMP_RESET}; // R2
			cmp_b_reg <= {trace_unit_pkg::CMP_RESET, trace_unit_pkg::CMP_RESET};
			trig_reg <= trace_unit_pkg::TRIG_RESET;
		end else if (reg_wr && !armed) begin // R2 R3
			if (reg_addr == trace_unit_pkg::OFS_CMP_A_HIGH) begin
				cmp_a_reg[15:8] <= reg_wdata; // R1 R2
			end else if (reg_addr == trace_unit_pkg::OFS_CMP_A_LOW) begin
				cmp_a_reg[7:0] <= reg_wdata; // R1
			end else if (reg_addr == trace_unit_pkg::OFS_CMP_B_HIGH) begin
				cmp_b_reg[15:8] <= reg_wdata; // R1
			end else if (reg_addr == trace_unit_pkg::OFS_CMP_B_LOW) begin
				cmp_b_reg[7:0] <= reg_wdata; // R1
			end else if (reg_addr == trace_unit_pkg::OFS_TRIGGER) begin
				trig_reg <= reg_wdata & trace_unit_pkg::TRIG_WRITE_MASK;
			end
			// Buffer offsets have no write decode at all
		end
	end

	// Run sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			trace_unit_pkg::RUN_IDLE: begin
				if (arm_rise) begin
					// End traces and plain event-only store from the start
					if (!begin_trace || trig_reg[3:0] == trace_unit_pkg::MODE_EVT_B) begin
						state_next = trace_unit_pkg::RUN_STORE;
					end else begin
						state_next = trace_unit_pkg::RUN_WAIT;
					end
				end
			end
			trace_unit_pkg::RUN_WAIT: begin
				if (trig_reg[3:0] == trace_unit_pkg::MODE_A_EVT_B) begin
					if (a_ev) begin
						state_next = trace_unit_pkg::RUN_STORE; // R19
					end
				end else if (trig_ev) begin
					state_next = trace_unit_pkg::RUN_STORE;
				end
			end
			trace_unit_pkg::RUN_STORE: begin
				if (run_done) begin
					state_next = trace_unit_pkg::RUN_IDLE;
				end
			end
			default: state_next = trace_unit_pkg::RUN_IDLE;
		endcase
		// Manual stop from software
		if (!ctrl_next[trace_unit_pkg::CTRL_ARM_BIT] && !arm_rise) begin
			state_next = trace_unit_pkg::RUN_IDLE; // R12
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= trace_unit_pkg::RUN_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Match flags and valid count, cleared at run start
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			af_reg <= 1'b0;
			bf_reg <= 1'b0;
			cnt_reg <= 4'h0;
		end else if (arm_rise) begin
			af_reg <= 1'b0;
			bf_reg <= 1'b0;
			cnt_reg <= 4'h0;
		end else begin
			af_reg <= af_reg || a_ev;
			bf_reg <= bf_reg || b_ev;
			// Saturates; end traces keep overwriting the oldest word
			if (fport.push && cnt_reg != trace_unit_pkg::FIFO_FULL) begin
				cnt_reg <= 4'(cnt_reg + 4'h1);
			end
		end
	end

	// Latest opcode fetch address for profiling
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			last_fetch_reg <= '0;
		end else if (cpu_valid && cpu_fetch) begin
			last_fetch_reg <= cpu_addr;
		end
	end

	// Break request, same cycle for either qualification style
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			brk_req_reg <= 1'b0;
			brk_tag_reg <= 1'b0;
		end else begin
			brk_req_reg <= run_done && ctrl_reg[trace_unit_pkg::CTRL_BREAK_REQUEST_ENABLE_BIT]; // R14 R17
			brk_tag_reg <= ctrl_reg[trace_unit_pkg::CTRL_TAG_BIT] &&
				ctrl_reg[trace_unit_pkg::CTRL_BREAK_REQUEST_ENABLE_BIT]; // R13
		end
	end

	// Read multiplexer; unmapped indices read zero
	always_comb begin
		rd_mux = trace_unit_pkg::ZERO_BYTE;
		if (reg_addr == trace_unit_pkg::OFS_CMP_A_HIGH) begin
			rd_mux = cmp_a_reg[15:8];
		end else if (reg_addr == trace_unit_pkg::OFS_CMP_A_LOW) begin
			rd_mux = cmp_a_reg[7:0];
		end else if (reg_addr == trace_unit_pkg::OFS_CMP_B_HIGH) begin
			rd_mux = cmp_b_reg[15:8];
		end else if (reg_addr == trace_unit_pkg::OFS_CMP_B_LOW) begin
			rd_mux = cmp_b_reg[7:0];
		end else if (reg_addr == trace_unit_pkg::OFS_FIFO_HIGH) begin
			rd_mux = event_only ? trace_unit_pkg::ZERO_BYTE : fport.head[15:8]; // R4 R5
		end else if (reg_addr == trace_unit_pkg::OFS_FIFO_LOW) begin
			rd_mux = fport.head[7:0]; // R6
		end else if (reg_addr == trace_unit_pkg::OFS_CONTROL) begin
			rd_mux = ctrl_reg; // R10
		end else if (reg_addr == trace_unit_pkg::OFS_TRIGGER) begin
			rd_mux = trig_reg;
		end else if (reg_addr == trace_unit_pkg::OFS_STATUS) begin
			rd_mux = {af_reg, bf_reg, armed, 1'b0, cnt_reg};
		end
	end

	// Read data latched on the read strobe
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_reg <= trace_unit_pkg::ZERO_BYTE;
		end else if (reg_rd) begin
			rdata_reg <= rd_mux;
		end
	end

	assign reg_rdata = rdata_reg;
	assign brk_req = brk_req_reg;
	assign brk_tag = brk_tag_reg;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_cmp_locked: assert property ( // R2
		reg_wr && reg_addr <= trace_unit_pkg::OFS_CMP_B_LOW && armed |=>
		$stable(cmp_a_reg) && $stable(cmp_b_reg))
		else $error("comparator written while armed");
	a_high_zero_event: assert property ( // R4
		reg_rd && reg_addr == trace_unit_pkg::OFS_FIFO_HIGH && event_only |=> reg_rdata == 8'h00)
		else $error("buffer high byte nonzero in event mode");
	a_high_no_shift: assert property ( // R5
		reg_rd && reg_addr == trace_unit_pkg::OFS_FIFO_HIGH && !fport.push |=> $stable(fport.head))
		else $error("high byte read moved the buffer");
	a_low_advances: assert property ( // R6
		reg_rd && reg_addr == trace_unit_pkg::OFS_FIFO_LOW && !armed |-> fport.pop)
		else $error("unarmed low read did not advance");
	a_armed_no_pop: assert property ( // R7
		armed |-> !fport.pop)
		else $error("buffer advanced while armed");
	a_secure_enable: assert property ( // R11
		cpu_secure && !ctrl_reg[trace_unit_pkg::CTRL_ENABLE_BIT] |=>
		!ctrl_reg[trace_unit_pkg::CTRL_ENABLE_BIT])
		else $error("enable set while secure");
	a_arm_flag: assert property ( // R12
		reg_wr && reg_addr == trace_unit_pkg::OFS_CONTROL && reg_wdata[7:6] == 2'b11 && !cpu_secure
		|=> armed ##0 rd_mux[5] || reg_addr != trace_unit_pkg::OFS_STATUS)
		else $error("arm write did not set armed flag");
	a_break_type: assert property ( // R13
		brk_req |-> brk_tag == $past(ctrl_reg[trace_unit_pkg::CTRL_TAG_BIT]))
		else $error("break type does not follow tag bit");
	a_break_timing: assert property ( // R14
		run_done && ctrl_reg[trace_unit_pkg::CTRL_BREAK_REQUEST_ENABLE_BIT] |=> brk_req ##1 !brk_req)
		else $error("break request not a one-cycle pulse after trigger");
	a_no_break_off: assert property ( // R14
		!ctrl_reg[trace_unit_pkg::CTRL_BREAK_REQUEST_ENABLE_BIT] |=> !brk_req)
		else $error("break request while breaks disabled");
	a_full_ends_run: assert property ( // R18
		run_done && !(reg_wr && reg_addr == trace_unit_pkg::OFS_CONTROL) |=>
		!armed && state_reg == trace_unit_pkg::RUN_IDLE)
		else $error("run did not end on completion");
	a_disabled_quiet: assert property ( // R20
		!ctrl_reg[trace_unit_pkg::CTRL_ENABLE_BIT] |-> !hit_a && !hit_b && !fport.push && !trig_ev)
		else $error("activity while unit disabled");

	c_begin_full_break: cover property (begin_trace && run_done ##1 brk_req);
	c_end_trigger: cover property (!begin_trace && run_done);
	c_event_store: cover property (event_only && fport.push);
endmodule

//--- bench/cpu_bus_model.sv
module cpu_bus_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Access request from the bench
	input wire logic go,
	input wire logic [15:0] go_addr,
	input wire logic [7:0] go_data,
	input wire logic go_rw,
	input wire logic go_fetch,
	// Bus seen by the trace unit
	output logic [15:0] cpu_addr,
	output logic [7:0] cpu_data,
	output logic cpu_rw,
	output logic cpu_valid,
	output logic cpu_fetch,
	// Break requests taken by the core
	input wire logic brk_req,
	input wire logic brk_tag,
	output int brk_count,
	output logic last_tag
);
	timeunit 1ns;
	timeprecision 100ps;

	// One access per request; an idle bus shows inverted junk, never a stale match
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cpu_valid <= 1'b0;
			cpu_fetch <= 1'b0;
			cpu_rw <= 1'b1;
			cpu_addr <= 16'h0000;
			cpu_data <= 8'h00;
		end else if (go) begin
			cpu_valid <= 1'b1;
			cpu_fetch <= go_fetch;
			cpu_rw <= go_rw;
			cpu_addr <= go_addr;
			cpu_data <= go_data;
		end else begin
			cpu_valid <= 1'b0;
			cpu_fetch <= 1'b0;
			cpu_addr <= ~cpu_addr;
			cpu_data <= ~cpu_data;
		end
	end

	// Core takes every break pulse and remembers its kind
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			brk_count <= 0;
			last_tag <= 1'b0;
		end else if (brk_req) begin
			brk_count <= brk_count + 1;
			last_tag <= brk_tag;
		end
	end
endmodule

//--- bench/trace_unit_tb.sv
module trace_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// Design side
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic cpu_secure = 1'b0;
	// Bus model side
	logic go = 1'b0;
	logic [15:0] go_addr = 16'h0000;
	logic [7:0] go_data = 8'h00;
	logic go_rw = 1'b0;
	logic go_fetch = 1'b0;
	logic [15:0] cpu_addr;
	logic [7:0] cpu_data;
	logic cpu_rw, cpu_valid, cpu_fetch, brk_req, brk_tag, last_tag;
	int brk_count;
	// Tallies
	int err_total = 0;
	int tests_run = 0;

	always #5 ref_clk = ~ref_clk;

	trace_unit #(.AW(16)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_rw(cpu_rw), .cpu_valid(cpu_valid),
		.cpu_fetch(cpu_fetch), .cpu_secure(cpu_secure), .brk_req(brk_req), .brk_tag(brk_tag));

	cpu_bus_model u_cpu (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .go_addr(go_addr),
		.go_data(go_data), .go_rw(go_rw), .go_fetch(go_fetch), .cpu_addr(cpu_addr),
		.cpu_data(cpu_data), .cpu_rw(cpu_rw), .cpu_valid(cpu_valid), .cpu_fetch(cpu_fetch),
		.brk_req(brk_req), .brk_tag(brk_tag), .brk_count(brk_count), .last_tag(last_tag));

	// Control readback: enable dropped when secure, arm needs enable
	function automatic logic [7:0] ctrl_exp(input logic [7:0] w, input logic sec);
		logic en;
		en = w[7] & ~sec;
		return {en, w[6] & en, w[5:0]};
	endfunction

	task automatic conclude();
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One write strobe, held for exactly one taking edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data lands at the taking edge and is sampled 1ns later
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic rw, input logic f);
		@(posedge ref_clk);
		go <= 1'b1;
		go_addr <= a;
		go_data <= d;
		go_rw <= rw;
		go_fetch <= f;
		@(posedge ref_clk);
		go <= 1'b0;
	endtask

	// Bounded wait for the next break pulse
	task automatic wait_brk(input int n0);
		int i;
		for (i = 0; i < 20 && brk_count == n0; i++)
			@(posedge ref_clk);
		if (brk_count == n0) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, n0, n0 + 1);
			conclude();
		end
	endtask

	// Overall limit, far above the real run length
	initial begin
		#900us;
		err_total++;
		conclude();
	end

	initial begin
		logic [7:0] v, w;
		logic [7:0] cv [4];
		logic [15:0] fa [8];
		logic [7:0] dv [8];
		logic [15:0] xa, xb, e;
		logic s;
		int n;
		void'($urandom(98));
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Reset values and an unmapped index
		for (int a = 0; a < 4; a++) begin
			rd(4'(a), v);
			chk(v, 16'h0000);
		end
		rd(trace_unit_pkg::OFS_CONTROL, v);
		chk(v, 16'h0000);
		rd(4'hf, v);
		chk(v, 16'h0000);
		$display("reset values done");
		// Profiling: each low read shifts in the last fetch address
		for (int k = 0; k < 16; k++) begin
			e = (k < 8) ? 16'h0000 : fa[k % 8];
			fa[k % 8] = 16'($urandom);
			acc(fa[k % 8], 8'h00, 1'b1, 1'b1);
			rd(trace_unit_pkg::OFS_FIFO_HIGH, v);
			rd(trace_unit_pkg::OFS_FIFO_HIGH, w);
			chk({v, w}, {e[15:8], e[15:8]});
			rd(trace_unit_pkg::OFS_FIFO_LOW, v);
			chk(v, e[7:0]);
		end
		// Back-to-back low reads refill every slot with the latest fetch
		@(posedge ref_clk);
		reg_addr <= trace_unit_pkg::OFS_FIFO_LOW;
		reg_rd <= 1'b1;
		repeat (8) @(posedge ref_clk);
		reg_rd <= 1'b0;
		rd(trace_unit_pkg::OFS_FIFO_LOW, v);
		chk(v, fa[7][7:0]);
		$display("profiling done");
		// Random register traffic, with secure state mixed in
		for (int i = 0; i < 8; i++) begin
			for (int a = 0; a < 4; a++) begin
				cv[a] = 8'($urandom);
				wr(4'(a), cv[a]);
			end
			wr(trace_unit_pkg::OFS_FIFO_HIGH, 8'($urandom));
			wr(trace_unit_pkg::OFS_FIFO_LOW, 8'($urandom));
			for (int a = 0; a < 4; a++) begin
				rd(4'(a), v);
				chk(v, cv[a]);
			end
			s = (i == 0) ? 1'b1 : 1'($urandom);
			w = (i == 0) ? 8'h80 : (8'($urandom) & 8'hbf);
			@(posedge ref_clk);
			cpu_secure <= s;
			wr(trace_unit_pkg::OFS_CONTROL, w);
			rd(trace_unit_pkg::OFS_CONTROL, v);
			chk(v, ctrl_exp(w, s));
		end
		cpu_secure <= 1'b0;
		$display("register access done");
		// End trace, A or B, both directions, tag and force
		for (int c = 0; c < 8; c++) begin
			xa = 16'($urandom);
			xb = ~xa;
			wr(trace_unit_pkg::OFS_CONTROL, 8'h00);
			wr(trace_unit_pkg::OFS_CMP_A_HIGH, xa[15:8]);
			wr(trace_unit_pkg::OFS_CMP_A_LOW, xa[7:0]);
			wr(trace_unit_pkg::OFS_CMP_B_HIGH, xb[15:8]);
			wr(trace_unit_pkg::OFS_CMP_B_LOW, xb[7:0]);
			wr(trace_unit_pkg::OFS_TRIGGER, (c[2] ? 8'h01 : 8'h00) | (c[0] ? 8'h80 : 8'h00));
			w = 8'hd0 | (c[0] ? 8'h20 : 8'h00);
			w = w | (c[2] ? {6'h00, c[1], 1'b1} : {4'h0, c[1], 3'b100});
			wr(trace_unit_pkg::OFS_CONTROL, w);
			rd(trace_unit_pkg::OFS_CONTROL, v);
			chk(v, w);
			rd(trace_unit_pkg::OFS_STATUS, v);
			chk(v[5], 1'b1);
			wr(trace_unit_pkg::OFS_CMP_A_LOW, ~xa[7:0]);
			rd(trace_unit_pkg::OFS_CMP_A_LOW, v);
			chk(v, xa[7:0]);
			n = brk_count;
			acc(c[2] ? xb : xa, 8'h00, ~c[1], c[0]);
			// Fetch qualification on: a plain data access must not trigger
			if (c[0])
				acc(c[2] ? xb : xa, 8'h00, c[1], 1'b0);
			repeat (6) @(posedge ref_clk);
			chk(16'(brk_count), 16'(n));
			acc(c[2] ? xb : xa, 8'h00, c[1], c[0]);
			wait_brk(n);
			chk(last_tag, c[0]);
			rd(trace_unit_pkg::OFS_CONTROL, v);
			chk(v, w & 8'hbf);
		end
		$display("end trace done");
		// Disabled unit: arm refused, no break
		wr(trace_unit_pkg::OFS_CONTROL, 8'h50);
		rd(trace_unit_pkg::OFS_CONTROL, v);
		chk(v, ctrl_exp(8'h50, 1'b0));
		n = brk_count;
		acc(xa, 8'h00, 1'b0, 1'b1);
		repeat (6) @(posedge ref_clk);
		chk(16'(brk_count), 16'(n));
		$display("disabled unit done");
		// Event-only modes store data bytes, break when full
		for (int m = 3; m < 5; m++) begin
			wr(trace_unit_pkg::OFS_TRIGGER, 8'(m));
			wr(trace_unit_pkg::OFS_CONTROL, 8'hd0);
			n = brk_count;
			if (m == 4)
				acc(xa, 8'h00, 1'b0, 1'b0);
			for (int i = 0; i < 8; i++) begin
				dv[i] = 8'($urandom);
				acc(xb, dv[i], 1'b0, 1'b0);
			end
			wait_brk(n);
			rd(trace_unit_pkg::OFS_STATUS, v);
			chk(v[5:0], 6'h08);
			for (int i = 0; i < 8; i++) begin
				rd(trace_unit_pkg::OFS_FIFO_HIGH, v);
				chk(v, 8'h00);
				rd(trace_unit_pkg::OFS_FIFO_LOW, v);
				chk(v, dv[i]);
			end
		end
		$display("event-only done");
		conclude();
	end
endmodule
